// *** shared/tsm_params.svh ***
// Constants for the thermometer / memory slave controller.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef TSM_PARAMS_SVH
`define TSM_PARAMS_SVH

// ==========================================================================
// Command bytes following the write address
`define TSM_CMD_MEM         8'h17
`define TSM_CMD_CFG         8'hac
`define TSM_CMD_TEMP        8'haa
`define TSM_CMD_START       8'hee
`define TSM_CMD_STOP        8'h22

// ==========================================================================
// Configuration/status byte layout
`define TSM_CFG_DONE_BIT    7
`define TSM_CFG_SINGLE_BIT  0
`define TSM_CFG_FIXED       6'h25
`define TSM_CFG_SINGLE_RST  1'b0

// ==========================================================================
// Temperature result
`define TSM_TEMP_W          13
`define TSM_TEMP_PRESET     13'h1920
`define TSM_RESULT_RST      16'h0000

// ==========================================================================
// Memory and page buffer
`define TSM_MEM_DEPTH       256
`define TSM_PAGE_BYTES      8

// ==========================================================================
// Timing
`define TSM_CLK_MHZ         100
`define TSM_PROG_TIME_US    10000
`define TSM_PROG_CYCLES     (`TSM_PROG_TIME_US * `TSM_CLK_MHZ)

// ==========================================================================
// Measurement defaults
`define TSM_CNT_W           16
`define TSM_BASE_COUNT      16'h0100
`define TSM_SLOPE_INIT      16'h0010
`define TSM_SLOPE_STEP      16'h0001

`endif

// *** shared/tsm_pkg.sv ***
// Types shared by the thermometer / memory slave controller.
// Assumes nothing of its surroundings.
package tsm_pkg;

  // ========================================================================
  // Serial link states
  typedef enum logic [2:0] {
    LK_IDLE,
    LK_RX,
    LK_RACK,
    LK_TX,
    LK_TACK
  } tsm_link_t;

  // ========================================================================
  // Measurement states
  typedef enum logic [1:0] {
    ME_IDLE,
    ME_WAIT,
    ME_COUNT
  } tsm_meas_t;

endpackage : tsm_pkg

// *** rtl/tsm_ctrl.sv ***
// Two-wire slave for a thermometer with 256-byte nonvolatile memory.
// Assumes an open-drain SDA resolved outside; SCL only from the master.
//
// Overview of operation
// - Conversion start presets counter to base count and result to -55 degrees.
// - Each zero crossing in the gate window reloads counter from slope accumulator.
// - Result is 13-bit two's complement, 1/32 degree LSB, left-justified in 16 bits.
// - Result bytes shift out most significant bit first.
// - First byte whole degrees; second byte fraction in top five bits, low three zero.
// - Encoding gives 7D00h at 125, FF80h at -0.5, C900h at -55 degrees.
// - Done flag reads 1 after conversion completes, 0 while converting.
// - Single mode performs exactly one conversion per start command.
// - Continuous mode converts back to back after start.
// - Single select bit is volatile, reset value 0; a write takes effect on STOP.
// - Config byte: done in bit 7, single select bit 0, bits 6..1 fixed 100101.
// - Byte write: address, memory command, word address, data; STOP programs.
// - Repeated START instead of STOP discards the pending write.
// - No acknowledge to any addressing during the 10 ms programming cycle.
// - Page write acknowledges each byte into an 8-byte buffer; STOP programs.
// - Page write increments only low 3 pointer bits; extra bytes wrap over.
// - STOP after first data byte is a single-byte write.
// - Memory read: set pointer, repeated START read, bytes with auto increment.
// - Sequential read continues until master ends it with no acknowledge.
// - Read pointer wraps from FFh to 00h.
// - Command 17h memory, ACh config, AAh temperature read.
// - EEh starts conversion, 22h stops continuous run after current one.
// - Temperature command returns two bytes of latest completed result.
`timescale 1ns/1ps
`include "tsm_params.svh"

module tsm_ctrl #(
  parameter int                 PROG_CYCLES = `TSM_PROG_CYCLES,
  parameter int                 CNT_W       = `TSM_CNT_W,
  parameter logic [CNT_W-1:0]   BASE_COUNT  = `TSM_BASE_COUNT,
  parameter logic [CNT_W-1:0]   SLOPE_INIT  = `TSM_SLOPE_INIT,
  parameter logic [CNT_W-1:0]   SLOPE_STEP  = `TSM_SLOPE_STEP
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic osc_clk_i,
  input  wire logic gate_i
);

  localparam int PW = $clog2(PROG_CYCLES + 1);
  localparam int TW = `TSM_TEMP_W;

  // ========================================================================
  // Pin synchronisers and bus conditions
  logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
  always_ff @(posedge clk_i) begin
    scl_s1 <= scl_i;
    scl_s2 <= scl_s1;
    scl_q  <= scl_s2;
    sda_s1 <= sda_i;
    sda_s2 <= sda_s1;
    sda_q  <= sda_s2;
  end
  wire scl_rise  = scl_s2 & ~scl_q;
  wire scl_fall  = ~scl_s2 & scl_q;
  wire start_det = scl_s2 & scl_q & sda_q & ~sda_s2;
  wire stop_det  = scl_s2 & scl_q & ~sda_q & sda_s2;

  // ========================================================================
  // State
  tsm_pkg::tsm_link_t st_reg;
  logic [3:0]       bit_cnt_reg;
  logic [7:0]       rx_shift_reg, tx_shift_reg, cmd_reg, ptr_reg;
  logic [1:0]       byte_idx_reg;
  logic             rw_reg, sda_oe_reg, mst_ack_reg, tx_hi_reg;
  logic [7:0]       mem_reg [`TSM_MEM_DEPTH];
  logic [7:0]       page_reg [`TSM_PAGE_BYTES];
  logic [7:0]       page_vld_reg;
  logic             cfg_pend_reg, cfg_val_reg, single_sel_reg;
  logic [PW-1:0]    prog_cnt_reg;
  logic             conv_active_reg, cont_reg, start_tgl_reg;
  logic [15:0]      temp_result_reg;
  logic             d_s1, d_s2, d_q;
  logic             m_done_tgl_reg;
  logic [TW-1:0]    m_result_reg;

  // ========================================================================
  // Byte events
  wire       busy     = (prog_cnt_reg != '0);
  wire       rx_done  = (st_reg == tsm_pkg::LK_RX) && scl_fall && (bit_cnt_reg == 4'h8);
  wire       addr_ev  = rx_done && (byte_idx_reg == 2'h0);
  wire       cmd_ev   = rx_done && (byte_idx_reg == 2'h1) && !rw_reg;
  wire       data_ev  = rx_done && byte_idx_reg[1] && !rw_reg;
  wire       tx_load  = ((st_reg == tsm_pkg::LK_RACK) && scl_fall && rw_reg
                         && (byte_idx_reg == 2'h1))
                        || ((st_reg == tsm_pkg::LK_TACK) && scl_fall && mst_ack_reg);
  wire       start_cmd = cmd_ev && (rx_shift_reg == `TSM_CMD_START);
  wire       stop_cmd  = cmd_ev && (rx_shift_reg == `TSM_CMD_STOP);
  wire       wr_pend   = (page_vld_reg != 8'h00) || cfg_pend_reg;
  wire       done_ev   = d_s2 ^ d_q;
  wire [7:0] cfg_byte  = {~conv_active_reg, `TSM_CFG_FIXED, single_sel_reg};

  // Byte to send next, chosen by the last command
  logic [7:0] tx_byte;
  always_comb begin
    unique case (cmd_reg)
      `TSM_CMD_MEM:  tx_byte = mem_reg[ptr_reg];
      `TSM_CMD_CFG:  tx_byte = cfg_byte;
      `TSM_CMD_TEMP: tx_byte = tx_hi_reg ? temp_result_reg[15:8]
                                         : temp_result_reg[7:0];
      default:       tx_byte = 8'hff;
    endcase
  end

  // ========================================================================
  // Link state machine
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg       <= tsm_pkg::LK_IDLE;
      bit_cnt_reg  <= 4'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      rw_reg       <= 1'b0;
      sda_oe_reg   <= 1'b0;
      mst_ack_reg  <= 1'b0;
      cmd_reg      <= 8'h00;
    end else if (start_det) begin
      // Command survives a repeated start so a read can follow it
      st_reg       <= tsm_pkg::LK_RX;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= 2'h0;
      sda_oe_reg   <= 1'b0;
    end else if (stop_det) begin
      st_reg     <= tsm_pkg::LK_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        tsm_pkg::LK_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        tsm_pkg::LK_RX: begin
          if (scl_rise) begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_s2};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          end else if (rx_done) begin
            if (addr_ev && busy) begin
              st_reg <= tsm_pkg::LK_IDLE;
            end else begin
              sda_oe_reg <= 1'b1;
              st_reg     <= tsm_pkg::LK_RACK;
              if (addr_ev) begin
                rw_reg <= rx_shift_reg[0];
              end
              if (cmd_ev) begin
                cmd_reg <= rx_shift_reg;
              end
              if (byte_idx_reg != 2'h3) begin
                byte_idx_reg <= byte_idx_reg + 2'h1;
              end
            end
          end
        end
        tsm_pkg::LK_RACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (tx_load) begin
              tx_shift_reg <= tx_byte;
              sda_oe_reg   <= ~tx_byte[7];
              st_reg       <= tsm_pkg::LK_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              st_reg     <= tsm_pkg::LK_RX;
            end
          end
        end
        tsm_pkg::LK_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_reg <= 1'b0;
              st_reg     <= tsm_pkg::LK_TACK;
            end else begin
              bit_cnt_reg  <= bit_cnt_reg + 4'h1;
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              sda_oe_reg   <= ~tx_shift_reg[6];
            end
          end
        end
        tsm_pkg::LK_TACK: begin
          if (scl_rise) begin
            mst_ack_reg <= ~sda_s2;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (mst_ack_reg) begin
              tx_shift_reg <= tx_byte;
              sda_oe_reg   <= ~tx_byte[7];
              st_reg       <= tsm_pkg::LK_TX;
            end else begin
              st_reg <= tsm_pkg::LK_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Temperature byte order: high byte first, then low
  always_ff @(posedge clk_i) begin
    if (reset_i || addr_ev) begin
      tx_hi_reg <= 1'b1;
    end else if (tx_load) begin
      tx_hi_reg <= ~tx_hi_reg;
    end
  end

  // ========================================================================
  // Pointer and page buffer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ptr_reg      <= 8'h00;
      page_vld_reg <= 8'h00;
    end else if (start_det || stop_det) begin
      page_vld_reg <= 8'h00;
    end else if (data_ev && cmd_reg == `TSM_CMD_MEM) begin
      if (byte_idx_reg == 2'h2) begin
        ptr_reg <= rx_shift_reg;
      end else begin
        page_reg[ptr_reg[2:0]]     <= rx_shift_reg;
        page_vld_reg[ptr_reg[2:0]] <= 1'b1;
        ptr_reg <= {ptr_reg[7:3], ptr_reg[2:0] + 3'h1};
      end
    end else if (tx_load && cmd_reg == `TSM_CMD_MEM) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // Memory array: commit only on STOP; contents have no reset
  always_ff @(posedge clk_i) begin
    if (!reset_i && stop_det && !busy) begin
      for (int i = 0; i < `TSM_PAGE_BYTES; i++) begin
        if (page_vld_reg[i]) begin
          mem_reg[{ptr_reg[7:3], 3'(i)}] <= page_reg[i];
        end
      end
    end
  end

  // ========================================================================
  // Configuration bit and programming timer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_pend_reg   <= 1'b0;
      cfg_val_reg    <= 1'b0;
      single_sel_reg <= `TSM_CFG_SINGLE_RST;
    end else if (start_det || stop_det) begin
      cfg_pend_reg <= 1'b0;
      if (stop_det && cfg_pend_reg) begin
        single_sel_reg <= cfg_val_reg;
      end
    end else if (data_ev && cmd_reg == `TSM_CMD_CFG && byte_idx_reg == 2'h2) begin
      cfg_pend_reg <= 1'b1;
      cfg_val_reg  <= rx_shift_reg[`TSM_CFG_SINGLE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prog_cnt_reg <= '0;
    end else if (stop_det && wr_pend && !busy) begin
      prog_cnt_reg <= PW'(PROG_CYCLES);
    end else if (busy) begin
      prog_cnt_reg <= prog_cnt_reg - PW'(1);
    end
  end

  // ========================================================================
  // Conversion control
  wire want_more = start_cmd || (cont_reg && !stop_cmd);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      conv_active_reg <= 1'b0;
      cont_reg        <= 1'b0;
      start_tgl_reg   <= 1'b0;
    end else begin
      if (start_cmd) begin
        cont_reg <= ~single_sel_reg;
      end else if (stop_cmd) begin
        cont_reg <= 1'b0;
      end
      if (done_ev) begin
        if (want_more) begin
          start_tgl_reg <= ~start_tgl_reg;
        end else begin
          conv_active_reg <= 1'b0;
        end
      end else if (start_cmd && !conv_active_reg) begin
        conv_active_reg <= 1'b1;
        start_tgl_reg   <= ~start_tgl_reg;
      end
    end
  end

  // Result is stable in the other domain once its done toggle is seen
  always_ff @(posedge clk_i) begin
    d_s1 <= m_done_tgl_reg;
    d_s2 <= d_s1;
    d_q  <= d_s2;
    if (reset_i) begin
      temp_result_reg <= `TSM_RESULT_RST;
    end else if (done_ev) begin
      temp_result_reg <= {m_result_reg, 3'b000};
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_reg;

  // ========================================================================
  // Measurement domain
  tsm_pkg::tsm_meas_t m_st_reg;
  logic m_rst_s1, m_rst, m_st_s1, m_st_s2, m_st_q, m_gate_s1, m_gate;
  logic [CNT_W-1:0] m_cnt_reg, m_slope_reg;
  logic [TW-1:0]    m_temp_reg;
  always_ff @(posedge osc_clk_i) begin
    m_rst_s1  <= reset_i;
    m_rst     <= m_rst_s1;
    m_st_s1   <= start_tgl_reg;
    m_st_s2   <= m_st_s1;
    m_st_q    <= m_st_s2;
    m_gate_s1 <= gate_i;
    m_gate    <= m_gate_s1;
  end
  wire m_start = m_st_s2 ^ m_st_q;

  always_ff @(posedge osc_clk_i) begin
    if (m_rst) begin
      m_st_reg       <= tsm_pkg::ME_IDLE;
      m_cnt_reg      <= '0;
      m_slope_reg    <= '0;
      m_temp_reg     <= '0;
      m_result_reg   <= '0;
      m_done_tgl_reg <= 1'b0;
    end else if (m_start) begin
      m_st_reg    <= tsm_pkg::ME_WAIT;
      m_cnt_reg   <= BASE_COUNT;
      m_slope_reg <= SLOPE_INIT;
      m_temp_reg  <= `TSM_TEMP_PRESET;
    end else begin
      unique case (m_st_reg)
        tsm_pkg::ME_IDLE: begin
        end
        tsm_pkg::ME_WAIT: begin
          if (m_gate) begin
            m_st_reg <= tsm_pkg::ME_COUNT;
          end
        end
        tsm_pkg::ME_COUNT: begin
          if (!m_gate) begin
            m_result_reg   <= m_temp_reg;
            m_done_tgl_reg <= ~m_done_tgl_reg;
            m_st_reg       <= tsm_pkg::ME_IDLE;
          end else if (m_cnt_reg == '0) begin
            m_temp_reg  <= m_temp_reg + TW'(1);
            m_cnt_reg   <= m_slope_reg;
            m_slope_reg <= m_slope_reg + SLOPE_STEP;
          end else begin
            m_cnt_reg <= m_cnt_reg - CNT_W'(1);
          end
        end
      endcase
    end
  end

  // ========================================================================
  // Assertions
  meas_preset_a: assert property (@(posedge osc_clk_i) disable iff (m_rst)
    m_start |=> m_temp_reg == `TSM_TEMP_PRESET && m_cnt_reg == BASE_COUNT)
    else $error("preset missing");
  slope_reload_a: assert property (@(posedge osc_clk_i) disable iff (m_rst)
    m_st_reg == tsm_pkg::ME_COUNT && m_gate && m_cnt_reg == '0 && !m_start
    |=> m_cnt_reg == $past(m_slope_reg) && m_temp_reg == $past(m_temp_reg) + TW'(1))
    else $error("reload wrong");
  low_bits_a: assert property (@(posedge clk_i) disable iff (reset_i)
    done_ev |=> temp_result_reg[2:0] == 3'b000
      && temp_result_reg[15:3] == $past(m_result_reg))
    else $error("result format");
  done_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
    start_cmd && !conv_active_reg && !done_ev |=> !cfg_byte[7])
    else $error("done flag");
  one_shot_a: assert property (@(posedge clk_i) disable iff (reset_i)
    done_ev && !want_more |=> cfg_byte[7] && $stable(start_tgl_reg))
    else $error("single run");
  cont_run_a: assert property (@(posedge clk_i) disable iff (reset_i)
    done_ev && cont_reg && !stop_cmd |=> conv_active_reg && start_tgl_reg != $past(start_tgl_reg))
    else $error("continuous");
  busy_nack_a: assert property (@(posedge clk_i) disable iff (reset_i)
    addr_ev && busy && !start_det && !stop_det |=> !sda_oe_reg [*2])
    else $error("ack while busy");
  abort_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
    start_det && wr_pend && !busy |=> page_vld_reg == 8'h00 && !busy)
    else $error("abort failed");
  stop_prog_a: assert property (@(posedge clk_i) disable iff (reset_i)
    stop_det && wr_pend && !busy |=> prog_cnt_reg == PW'(PROG_CYCLES))
    else $error("no programming");
  page_wrap_a: assert property (@(posedge clk_i) disable iff (reset_i)
    data_ev && cmd_reg == `TSM_CMD_MEM && byte_idx_reg == 2'h3 && !start_det && !stop_det
    |=> ptr_reg[7:3] == $past(ptr_reg[7:3]) && ptr_reg[2:0] == $past(ptr_reg[2:0]) + 3'h1)
    else $error("page pointer");
  read_wrap_a: assert property (@(posedge clk_i) disable iff (reset_i)
    tx_load && cmd_reg == `TSM_CMD_MEM && ptr_reg == 8'hff && !start_det && !stop_det
    |=> ptr_reg == 8'h00)
    else $error("read wrap");

  byte_write_c: cover property (@(posedge clk_i) disable iff (reset_i)
    stop_det && page_vld_reg == 8'h01);
  page_full_c: cover property (@(posedge clk_i) disable iff (reset_i)
    stop_det && page_vld_reg == 8'hff);
  temp_read_c: cover property (@(posedge clk_i) disable iff (reset_i)
    tx_load && cmd_reg == `TSM_CMD_TEMP && !tx_hi_reg);
  conv_done_c: cover property (@(posedge clk_i) disable iff (reset_i) done_ev);

endmodule : tsm_ctrl

// *** tb/tsm_master.sv ***
// Behavioural two-wire bus master driving the slave controller.
// Assumes a pull-up on SDA resolved by the bench from sda_low_o.
`timescale 1ns/1ps

module tsm_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ========================================================================
  // Bit timing: 0.6 us SCL period (60 clk cycles per bit), changes only at clk falling edge
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic hp;
    repeat (25) @(negedge clk_i);
  endtask : hp

  // Also serves as repeated start
  task automatic start;
    repeat (10) @(negedge clk_i);
    sda_low_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_low_o = 1'b1;
    hp();
    scl_o = 1'b0;
  endtask : start

  task automatic stop;
    repeat (10) @(negedge clk_i);
    sda_low_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_low_o = 1'b0;
    hp();
  endtask : stop

  // Delay after SCL fall keeps data edges away from start/stop detection
  task automatic bit_io(input logic b, output logic r);
    repeat (10) @(negedge clk_i);
    sda_low_o = !b;
    hp();
    scl_o = 1'b1;
    hp();
    r     = sda_i;
    scl_o = 1'b0;
  endtask : bit_io

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = (r === 1'b0);
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : tsm_master

// *** tb/tsm_ctrl_tb.sv ***
// Self-checking bench for the thermometer / memory slave controller.
// Assumes the master model in tsm_master.sv and the shared constants.
`timescale 1ns/1ps
`include "tsm_params.svh"

module tsm_ctrl_tb;
  // Long enough that an address right after a STOP still meets the busy window
  localparam int         PROG  = 1000;
  localparam logic [15:0] T_EXP = {13'(`TSM_TEMP_PRESET + 2), 3'b000}; // Two counts above -55
  localparam logic [7:0] ADR_W = 8'h4e; // Arbitrary, address is not matched
  localparam logic [7:0] ADR_R = 8'h4f;

  logic       clk_i;
  logic       reset_i;
  logic       osc_clk_i;
  logic       gate_i;
  logic       scl;
  logic       m_low;
  logic       sda_oe;
  wire logic  sda;
  logic       a;
  logic [7:0] d;
  logic [7:0] page [8];
  int         n_fail;
  int         n_compared;

  assign sda = !(m_low || sda_oe);

  tsm_ctrl #(.PROG_CYCLES(PROG)) uut (
    .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe), .osc_clk_i(osc_clk_i), .gate_i(gate_i));

  tsm_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  // ========================================================================
  // Clocks, unrelated in phase
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;
  initial osc_clk_i = 1'b0;
  always #3 osc_clk_i = ~osc_clk_i;

  // ========================================================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] c);
    m.start();
    m.wr_byte(ADR_W, a);
    chk("address ack", 16'h1, {15'h0, a});
    m.wr_byte(c, a);
    chk("command ack", 16'h1, {15'h0, a});
  endtask : cmd

  task automatic wr(input logic [7:0] v);
    m.wr_byte(v, a);
    chk("data ack", 16'h1, {15'h0, a});
  endtask : wr

  task automatic turn;
    m.start();
    m.wr_byte(ADR_R, a);
    chk("read address ack", 16'h1, {15'h0, a});
  endtask : turn

  task automatic rd(input logic last, input logic [7:0] exp);
    m.rd_byte(last, d);
    chk("read byte", {8'h0, exp}, {8'h0, d});
  endtask : rd

  // Master waits out the programming time before touching the device
  task automatic prog_wait;
    repeat (PROG + 50) @(negedge clk_i);
  endtask : prog_wait

  // Gate window of 280 oscillator edges: two zero crossings after the base count
  task automatic gate_pulse;
    @(negedge clk_i);
    gate_i = 1'b1;
    repeat (280) @(posedge osc_clk_i);
    @(negedge clk_i);
    gate_i = 1'b0;
    repeat (20) @(negedge clk_i);
  endtask : gate_pulse

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // ========================================================================
  // Watchdog, tests need about 0.6 ms
  initial begin
    #900000;
    n_fail++;
    final_report();
  end

  // ========================================================================
  // Tests
  initial begin
    n_fail = 0;
    n_compared = 0;
    reset_i = 1'b1;
    gate_i = 1'b0;
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (5) @(negedge clk_i);
    cmd(`TSM_CMD_CFG); turn(); rd(1'b1, {1'b1, `TSM_CFG_FIXED, 1'b0}); m.stop();
    $display("test config reset done");
    // Nine bytes from 3eh wrap inside the page
    cmd(`TSM_CMD_MEM); wr(8'h3e);
    for (int k = 0; k < 9; k++) begin
      wr(8'h10 + 8'(k));
      page[(6 + k) % 8] = 8'h10 + 8'(k);
    end
    m.stop();
    m.start(); m.wr_byte(ADR_W, a); chk("busy ack", 16'h0, {15'h0, a}); m.stop();
    prog_wait();
    cmd(`TSM_CMD_MEM); wr(8'h38); turn();
    for (int j = 0; j < 8; j++) begin
      rd(j == 7, page[j]);
    end
    m.stop();
    $display("test page write done");
    // Repeated start instead of stop must drop the write
    // Data byte moved the pointer to 39h although the write itself is dropped
    cmd(`TSM_CMD_MEM); wr(8'h38); wr(8'haa); turn(); rd(1'b1, page[1]); m.stop();
    cmd(`TSM_CMD_MEM); wr(8'h38); turn(); rd(1'b1, page[0]); m.stop();
    $display("test abort done");
    cmd(`TSM_CMD_MEM); wr(8'hff); wr(8'h5a); m.stop(); prog_wait();
    cmd(`TSM_CMD_MEM); wr(8'h00); wr(8'ha5); m.stop(); prog_wait();
    cmd(`TSM_CMD_MEM); wr(8'hff); turn(); rd(1'b0, 8'h5a); rd(1'b1, 8'ha5); m.stop();
    $display("test pointer wrap done");
    // Single conversion, gate long enough for two increments
    cmd(`TSM_CMD_CFG); wr(8'h01); m.stop(); prog_wait();
    cmd(`TSM_CMD_START); m.stop();
    cmd(`TSM_CMD_CFG); turn(); rd(1'b1, {1'b0, `TSM_CFG_FIXED, 1'b1}); m.stop();
    gate_pulse();
    cmd(`TSM_CMD_TEMP); turn();
    rd(1'b0, T_EXP[15:8]);
    rd(1'b1, T_EXP[7:0]);
    m.stop();
    cmd(`TSM_CMD_CFG); turn(); rd(1'b1, {1'b1, `TSM_CFG_FIXED, 1'b1}); m.stop();
    $display("test conversion done");
    // Continuous run, halted by the stop command after the current conversion
    cmd(`TSM_CMD_CFG); wr(8'h00); m.stop(); prog_wait();
    cmd(`TSM_CMD_START); m.stop();
    gate_pulse();
    cmd(`TSM_CMD_TEMP); turn();
    rd(1'b1, T_EXP[15:8]);
    m.stop();
    cmd(`TSM_CMD_CFG); turn(); rd(1'b1, {1'b0, `TSM_CFG_FIXED, 1'b0}); m.stop();
    cmd(`TSM_CMD_STOP); m.stop();
    gate_pulse();
    cmd(`TSM_CMD_CFG); turn(); rd(1'b1, {1'b1, `TSM_CFG_FIXED, 1'b0}); m.stop();
    $display("test continuous done");
    final_report();
  end
endmodule : tsm_ctrl_tb
